// ===== tcci_top.sv
// capture/compare interrupt logic of an extended function timer
//
// Implementation choices: the placing of the registers and the strobed register port.
`default_nettype none
module tcci_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic capture_one_pin,
    input wire logic capture_two_pin,
    output logic compare_one_pin,
    output logic compare_two_pin,
    output logic irq
);
    tcci_pkg::tcci_bus_req_t req;
    tcci_pkg::tcci_events_t ev;
    logic [7:0] control_first;
    logic [7:0] timer_control_third;
    logic [7:0] compare_one_value;
    logic [7:0] compare_two_value;
    logic [7:0] mask;
    logic [7:0] counter;
    logic [7:0] capture_one_value;
    logic [7:0] capture_two_value;
    logic [7:0] next_control_first;
    logic [7:0] next_timer_control_third;
    logic [7:0] next_compare_one_value;
    logic [7:0] next_compare_two_value;
    logic [7:0] next_mask;
    logic [7:0] next_counter;
    logic [7:0] next_capture_one_value;
    logic [7:0] next_capture_two_value;
    logic [7:0] next_rdata;
    logic next_compare_one_pin;
    logic next_compare_two_pin;
    logic cap1_rise;
    logic cap2_rise;
    logic pwm_mode;
    logic counting;
    logic match_one;
    logic match_two;
    logic [3:0] flags;
    logic [3:0] clear_bits;
    logic [3:0] set_bits;
    logic capture_one_irq_enable;
    logic compare_one_irq_enable;
    logic capture_two_irq_enable;
    logic compare_two_irq_enable;
    logic global_capture_irq_enable;
    logic global_compare_irq_enable;
    logic [3:0] enabled;
    logic next_irq;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    tcci_sync u_sync_cap1 (
        .clk(clk),
        .reset_n(reset_n),
        .pin(capture_one_pin),
        .rise(cap1_rise)
    );
    tcci_sync u_sync_cap2 (
        .clk(clk),
        .reset_n(reset_n),
        .pin(capture_two_pin),
        .rise(cap2_rise)
    );

    assign pwm_mode = control_first[tcci_pkg::cr1_pwm_mode];
    assign counting = control_first[tcci_pkg::cr1_count_enable];
    assign match_one = counting && (counter == compare_one_value);
    assign match_two = counting && (counter == compare_two_value);

    assign capture_one_irq_enable = timer_control_third[tcci_pkg::cr3_capture_one_ie];
    assign compare_one_irq_enable = timer_control_third[tcci_pkg::cr3_compare_one_ie];
    assign capture_two_irq_enable = timer_control_third[tcci_pkg::cr3_capture_two_ie];
    assign compare_two_irq_enable = timer_control_third[tcci_pkg::cr3_compare_two_ie];
    assign global_capture_irq_enable = control_first[tcci_pkg::cr1_global_capture_ie];
    assign global_compare_irq_enable = control_first[tcci_pkg::cr1_global_compare_ie];

    // hardware events
    always_comb begin
        ev.capture_one = cap1_rise;
        ev.capture_two = cap2_rise;
        ev.compare_one = match_one && !pwm_mode;
        ev.compare_two = match_two;
    end

    always_comb begin
        set_bits = 4'h0;
        set_bits[tcci_pkg::st_capture_one] = ev.capture_one;
        set_bits[tcci_pkg::st_capture_two] = ev.capture_two;
        set_bits[tcci_pkg::st_compare_one] = ev.compare_one;
        set_bits[tcci_pkg::st_compare_two] = ev.compare_two;
        clear_bits = 4'h0;
        if (req.wr && req.addr == tcci_pkg::addr_status) begin
            clear_bits = req.wdata[3:0];
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_flag
        tcci_flag u_flag (
            .clk(clk),
            .reset_n(reset_n),
            .set(set_bits[i]),
            .clear(clear_bits[i]),
            .flag(flags[i])
        );
    end

    // each flag is enabled by its per-event enable or by its global enable, whichever is set
    always_comb begin
        enabled = 4'h0;
        enabled[tcci_pkg::st_capture_one] = flags[tcci_pkg::st_capture_one]
            && (global_capture_irq_enable || capture_one_irq_enable);
        enabled[tcci_pkg::st_compare_one] = flags[tcci_pkg::st_compare_one]
            && (global_compare_irq_enable || compare_one_irq_enable);
        enabled[tcci_pkg::st_capture_two] = flags[tcci_pkg::st_capture_two]
            && (global_capture_irq_enable || capture_two_irq_enable);
        enabled[tcci_pkg::st_compare_two] = flags[tcci_pkg::st_compare_two]
            && (global_compare_irq_enable || compare_two_irq_enable);
        next_irq = |(enabled & mask[3:0]);
    end

    always_comb begin
        next_control_first = control_first;
        next_timer_control_third = timer_control_third;
        next_compare_one_value = compare_one_value;
        next_compare_two_value = compare_two_value;
        next_mask = mask;
        if (req.wr) begin
            unique case (req.addr)
                tcci_pkg::addr_control_first: next_control_first = req.wdata;
                tcci_pkg::addr_control_third: next_timer_control_third = req.wdata;
                tcci_pkg::addr_compare_one: next_compare_one_value = req.wdata;
                tcci_pkg::addr_compare_two: next_compare_two_value = req.wdata;
                tcci_pkg::addr_mask: next_mask = req.wdata & tcci_pkg::status_used;
                default: next_mask = mask;
            endcase
        end
    end

    // free-running counter; pwm wraps at the compare two match
    always_comb begin
        next_counter = counter;
        next_compare_one_pin = compare_one_pin;
        next_compare_two_pin = compare_two_pin;
        if (counting) begin
            next_counter = counter + tcci_pkg::counter_one;
            if (pwm_mode) begin
                if (match_two) begin
                    next_counter = tcci_pkg::reset_byte;
                    next_compare_one_pin = 1'b1;
                end else if (match_one) begin
                    next_compare_one_pin = 1'b0;
                end
            end else begin
                if (match_one) begin
                    next_compare_one_pin = ~compare_one_pin;
                end
                if (match_two) begin
                    next_compare_two_pin = ~compare_two_pin;
                end
            end
        end
        next_capture_one_value = ev.capture_one ? counter : capture_one_value;
        next_capture_two_value = ev.capture_two ? counter : capture_two_value;
    end

    always_comb begin
        next_rdata = tcci_pkg::reset_byte;
        if (req.rd) begin
            unique case (req.addr)
                tcci_pkg::addr_control_first: next_rdata = control_first;
                tcci_pkg::addr_control_third: next_rdata = timer_control_third;
                tcci_pkg::addr_compare_one: next_rdata = compare_one_value;
                tcci_pkg::addr_compare_two: next_rdata = compare_two_value;
                tcci_pkg::addr_status: next_rdata = {4'h0, flags};
                tcci_pkg::addr_mask: next_rdata = mask;
                tcci_pkg::addr_counter: next_rdata = counter;
                tcci_pkg::addr_capture_one: next_rdata = capture_one_value;
                tcci_pkg::addr_capture_two: next_rdata = capture_two_value;
                default: next_rdata = tcci_pkg::reset_byte;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_first <= tcci_pkg::reset_byte;
            timer_control_third <= tcci_pkg::reset_byte;
            compare_one_value <= tcci_pkg::reset_byte;
            compare_two_value <= tcci_pkg::reset_byte;
            mask <= tcci_pkg::reset_byte;
            counter <= tcci_pkg::reset_byte;
            capture_one_value <= tcci_pkg::reset_byte;
            capture_two_value <= tcci_pkg::reset_byte;
            rdata <= tcci_pkg::reset_byte;
            compare_one_pin <= 1'b0;
            compare_two_pin <= 1'b0;
            irq <= 1'b0;
        end else begin
            control_first <= next_control_first;
            timer_control_third <= next_timer_control_third;
            compare_one_value <= next_compare_one_value;
            compare_two_value <= next_compare_two_value;
            mask <= next_mask;
            counter <= next_counter;
            capture_one_value <= next_capture_one_value;
            capture_two_value <= next_capture_two_value;
            rdata <= next_rdata;
            compare_one_pin <= next_compare_one_pin;
            compare_two_pin <= next_compare_two_pin;
            irq <= next_irq;
        end
    end
endmodule
`default_nettype wire

// ===== tcci_pkg.sv
// shared constants and types of the timer capture/compare interrupt block
`default_nettype none
package tcci_pkg;
    localparam int addr_w = 4;
    localparam int data_w = 8;
    // register addresses
    localparam logic [3:0] addr_control_first = 4'h0;
    localparam logic [3:0] addr_control_third = 4'h2;
    localparam logic [3:0] addr_compare_one = 4'h3;
    localparam logic [3:0] addr_compare_two = 4'h4;
    localparam logic [3:0] addr_status = 4'h5;
    localparam logic [3:0] addr_mask = 4'h6;
    localparam logic [3:0] addr_counter = 4'h7;
    localparam logic [3:0] addr_capture_one = 4'h8;
    localparam logic [3:0] addr_capture_two = 4'h9;
    // field positions in timer_control_third
    localparam int cr3_capture_one_ie = 7;
    localparam int cr3_compare_one_ie = 6;
    localparam int cr3_capture_two_ie = 5;
    localparam int cr3_compare_two_ie = 4;
    // field positions in control_first
    localparam int cr1_global_capture_ie = 7;
    localparam int cr1_global_compare_ie = 6;
    localparam int cr1_pwm_mode = 5;
    localparam int cr1_count_enable = 4;
    // status / mask layout
    localparam int st_capture_one = 0;
    localparam int st_capture_two = 1;
    localparam int st_compare_one = 2;
    localparam int st_compare_two = 3;
    localparam logic [7:0] reset_byte = 8'h00;
    localparam logic [7:0] counter_one = 8'h01;
    localparam logic [7:0] status_used = 8'h0f;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tcci_bus_req_t;
    typedef struct packed {
        logic capture_one;
        logic capture_two;
        logic compare_one;
        logic compare_two;
    } tcci_events_t;
endpackage
`default_nettype wire

// ===== tcci_sync.sv
// two-flop synchroniser and rising edge detector for one pin
`default_nettype none
module tcci_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pin,
    output logic rise
);
    logic meta;
    logic stable;
    logic prev;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            stable <= meta;
            prev <= stable;
        end
    end
    assign rise = stable & ~prev;
endmodule
`default_nettype wire

// ===== tcci_flag.sv
// sticky event flag: hardware set beats write-one-to-clear
`default_nettype none
module tcci_flag (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic set,
    input wire logic clear,
    output logic flag
);
    logic next_flag;
    always_comb begin
        next_flag = flag;
        if (clear) begin
            next_flag = 1'b0;
        end
        if (set) begin
            next_flag = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule
`default_nettype wire

// ===== tcci_checker.sv
// assertion checker for the capture/compare interrupt block
`default_nettype none
module tcci_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0][7:0] sh, next_sh;
    logic pwm_clean, next_pwm_clean;
    logic [3:0] eff;
    logic [7:0] rbv;
    logic rd_rw, rd_st;
    // shadow of the writable registers, rebuilt from bus writes only
    always_comb begin
        next_sh = sh;
        next_pwm_clean = pwm_clean;
        if (wr) begin
            case (addr)
                tcci_pkg::addr_control_first: next_sh[0] = wdata;
                tcci_pkg::addr_control_third: next_sh[1] = wdata;
                tcci_pkg::addr_compare_one: next_sh[2] = wdata;
                tcci_pkg::addr_compare_two: next_sh[3] = wdata;
                // the mask keeps only the four flag positions
                tcci_pkg::addr_mask: next_sh[4] = wdata & tcci_pkg::status_used;
                default: ;
            endcase
        end
        // a compare one flag cleared while in pwm mode must stay clear
        if (wr && addr == tcci_pkg::addr_control_first && !wdata[5]) begin
            next_pwm_clean = 1'b0;
        end else if (wr && addr == tcci_pkg::addr_status && wdata[2] && sh[0][5]) begin
            next_pwm_clean = 1'b1;
        end
    end
    always_comb begin
        eff[0] = (sh[0][7] | sh[1][7]) & sh[4][0];
        eff[1] = (sh[0][7] | sh[1][5]) & sh[4][1];
        eff[2] = (sh[0][6] | sh[1][6]) & sh[4][2];
        eff[3] = (sh[0][6] | sh[1][4]) & sh[4][3];
        rd_st = rd && addr == tcci_pkg::addr_status;
        rd_rw = rd;
        case (addr)
            tcci_pkg::addr_control_first: rbv = sh[0];
            tcci_pkg::addr_control_third: rbv = sh[1];
            tcci_pkg::addr_compare_one: rbv = sh[2];
            tcci_pkg::addr_compare_two: rbv = sh[3];
            tcci_pkg::addr_mask: rbv = sh[4];
            default: begin
                rbv = 8'h00;
                rd_rw = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sh <= '0;
            pwm_clean <= 1'b0;
        end else begin
            sh <= next_sh;
            pwm_clean <= next_pwm_clean;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not zero outside read");
    a_unmapped_zero: assert property ($past(rd) && ($past(addr) == 4'h1 || $past(addr) > 4'h9)
        |-> rdata == 8'h00) else $error("unmapped read not zero");
    a_reg_readback: assert property ($past(rd_rw) |-> rdata == $past(rbv))
        else $error("register readback differs");
    a_status_upper: assert property ($past(rd_st) |-> rdata[7:4] == 4'h0) else $error("status upper bits set");
    a_pwm_no_cmp1: assert property ($past(rd_st) && $past(pwm_clean) |-> !rdata[2])
        else $error("compare one flag set in pwm mode");
    a_irq_raised: assert property ($past(rd_st) && (rdata[3:0] & $past(eff)) != 4'h0 |-> irq)
        else $error("irq low with enabled flag");
    a_irq_quiet: assert property ($past(rd_st) && (rdata[3:0] & $past(eff)) == 4'h0 |-> !irq)
        else $error("irq high without enabled flag");
    a_irq_off_disabled: assert property (eff == 4'h0 && $past(eff) == 4'h0
        && $past(eff, 2) == 4'h0 |-> !irq) else $error("irq high with all enables off");
    c_irq_high: cover property (irq);
    c_pwm_status: cover property (rd_st && sh[0][5]);
    c_unmapped: cover property (rd && addr == 4'h1);
endmodule
bind tcci_top tcci_checker u_chk (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq));
`default_nettype wire

// ===== tcci_pins_model.sv
// board-side driver that makes capture edges on request
`default_nettype none
module tcci_pins_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic fire_one,
    input wire logic fire_two,
    output logic capture_one_pin,
    output logic capture_two_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] w1, w2;
    // pulses last four cycles so the synchroniser cannot miss them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            w1 <= 3'h0;
            w2 <= 3'h0;
        end else begin
            w1 <= fire_one ? 3'h4 : w1 - {2'h0, w1 != 3'h0};
            w2 <= fire_two ? 3'h4 : w2 - {2'h0, w2 != 3'h0};
        end
    end
    assign capture_one_pin = w1 != 3'h0;
    assign capture_two_pin = w2 != 3'h0;
endmodule
`default_nettype wire

// ===== tcci_tb.sv
// self-checking testbench of the capture/compare interrupt block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fire_one = 1'b0;
    logic fire_two = 1'b0;
    logic [7:0] rdata;
    logic irq, cap1, cap2, cmp1, cmp2;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [3:0] regs [9] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h1, 4'hf};
    always #2.5 clk = ~clk;
    tcci_top dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .capture_one_pin(cap1), .capture_two_pin(cap2), .compare_one_pin(cmp1), .compare_two_pin(cmp2), .irq(irq));
    tcci_pins_model pins (.clk(clk), .reset_n(reset_n), .fire_one(fire_one), .fire_two(fire_two),
        .capture_one_pin(cap1), .capture_two_pin(cap2));
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmp_bit(input string what, input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp_byte("rdata", exp, rdata);
    endtask
    // irq is registered, so allow the flag and the enable a cycle each to land
    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge clk);
        #1 cmp_bit("irq", exp, irq);
    endtask
    task automatic fire(input logic two);
        @(posedge clk);
        fire_one <= !two;
        fire_two <= two;
        @(posedge clk);
        fire_one <= 1'b0;
        fire_two <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        foreach (regs[k]) rd_chk(regs[k], 8'h00);
        wr_reg(4'h1, 8'hff);
        rd_chk(4'h1, 8'h00);
        $display("test reset_map done");
        wr_reg(4'h6, 8'h0f);
        for (int i = 0; i < 2; i++) begin
            fire(i[0]);
            rd_chk(4'h5, 8'h01 << i);
            irq_chk(1'b0);
            wr_reg(4'h2, i[0] ? 8'h20 : 8'h80);
            irq_chk(1'b1);
            wr_reg(4'h2, i[0] ? 8'hd0 : 8'h70);
            irq_chk(1'b0);
            wr_reg(4'h2, 8'hf0);
            wr_reg(4'h5, 8'h0f);
            irq_chk(1'b0);
            wr_reg(4'h2, 8'h00);
        end
        $display("test capture_enables done");
        wr_reg(4'h0, 8'h80);
        fire(1'b0);
        irq_chk(1'b1);
        wr_reg(4'h6, 8'h00);
        irq_chk(1'b0);
        wr_reg(4'h6, 8'h0f);
        irq_chk(1'b1);
        wr_reg(4'h5, 8'h01);
        irq_chk(1'b0);
        $display("test global_capture done");
        wr_reg(4'h3, 8'h10);
        wr_reg(4'h4, 8'hff);
        wr_reg(4'h0, 8'h10);
        repeat (40) @(posedge clk);
        wr_reg(4'h0, 8'h00);
        rd_chk(4'h5, 8'h04);
        // count enable stood for 42 edges: one pass through compare one, none through compare two
        rd_chk(4'h7, 8'h2a);
        cmp_bit("compare_one_pin", 1'b1, cmp1);
        cmp_bit("compare_two_pin", 1'b0, cmp2);
        wr_reg(4'h2, 8'h10);
        irq_chk(1'b0);
        wr_reg(4'h2, 8'h40);
        irq_chk(1'b1);
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h0, 8'h40);
        irq_chk(1'b1);
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h5, 8'h0f);
        $display("test compare_one done");
        wr_reg(4'h4, 8'h08);
        wr_reg(4'h3, 8'h04);
        wr_reg(4'h0, 8'h30);
        repeat (300) @(posedge clk);
        wr_reg(4'h5, 8'h0f);
        repeat (12) @(posedge clk);
        rd_chk(4'h5, 8'h08);
        // pin two only holds in pwm mode
        cmp_bit("compare_two_pin", 1'b0, cmp2);
        irq_chk(1'b0);
        wr_reg(4'h2, 8'h10);
        irq_chk(1'b1);
        rd_chk(4'h5, 8'h08);
        wr_reg(4'h2, 8'h00);
        wr_reg(4'h0, 8'h70);
        irq_chk(1'b1);
        wr_reg(4'h0, 8'h30);
        irq_chk(1'b0);
        wr_reg(4'h0, 8'h00);
        $display("test pwm done");
        wrap_up();
    end
endmodule
`default_nettype wire
